// >>> src/add_group_pkg.sv
// constants and carriers for the integer add group decode/execute block
// assumes one processor clock and a sequencer on the same clock
package add_group_pkg;

    // opcode fields
    localparam logic [3:0] GRP_DECIMAL = 4'hc;
    localparam logic [3:0] GRP_ADD = 4'hd;
    localparam logic [3:0] ZERO_NIBBLE = 4'h0;

    // binary add and address add operation modes
    localparam logic [2:0] OPM_EA_TO_D_B = 3'h0;
    localparam logic [2:0] OPM_EA_TO_D_W = 3'h1;
    localparam logic [2:0] OPM_EA_TO_D_L = 3'h2;
    localparam logic [2:0] OPM_ADDR_W = 3'h3;
    localparam logic [2:0] OPM_D_TO_EA_B = 3'h4;
    localparam logic [2:0] OPM_D_TO_EA_W = 3'h5;
    localparam logic [2:0] OPM_D_TO_EA_L = 3'h6;
    localparam logic [2:0] OPM_ADDR_L = 3'h7;

    // effective address modes
    localparam logic [2:0] EA_DATA = 3'h0;
    localparam logic [2:0] EA_ADDR = 3'h1;
    localparam logic [2:0] EA_IND = 3'h2;
    localparam logic [2:0] EA_POSTINC = 3'h3;
    localparam logic [2:0] EA_PREDEC = 3'h4;
    localparam logic [2:0] EA_DISP = 3'h5;
    localparam logic [2:0] EA_INDEX = 3'h6;
    localparam logic [2:0] EA_EXT = 3'h7;
    // register codes under mode 7
    localparam logic [2:0] EXT_ABS_W = 3'h0;
    localparam logic [2:0] EXT_ABS_L = 3'h1;
    localparam logic [2:0] EXT_PC_DISP = 3'h2;
    localparam logic [2:0] EXT_PC_INDEX = 3'h3;
    localparam logic [2:0] EXT_IMM = 3'h4;

    // operand sizes
    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_WORD = 2'h1,
        SZ_LONG = 2'h2
    } size_t;

    typedef enum logic [1:0] {
        OP_NONE = 2'h0,
        OP_DECIMAL = 2'h1,
        OP_BINARY = 2'h2,
        OP_ADDR = 2'h3
    } op_t;

    // condition flag positions
    localparam int FL_C = 0;
    localparam int FL_V = 1;
    localparam int FL_Z = 2;
    localparam int FL_N = 3;
    localparam int FL_X = 4;
    localparam logic [4:0] CCR_RESET = 5'h00;

    // register port map
    localparam logic [3:0] REG_FLAGS = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam int ST_ILLEGAL = 0;
    localparam int ST_WAITING = 1;

    localparam logic [3:0] BCD_NINE = 4'h9;
    localparam logic [4:0] BCD_ADJ = 5'h06;

    // operand locations use the ea mode/register encoding
    typedef struct packed {
        logic illegal;
        op_t op;
        size_t size;
        logic [2:0] src_mode;
        logic [2:0] src_reg;
        logic [2:0] dst_mode;
        logic [2:0] dst_reg;
    } decode_t;

    localparam decode_t DECODE_RESET = '{
        illegal: 1'b0, op: OP_NONE, size: SZ_BYTE,
        src_mode: 3'h0, src_reg: 3'h0, dst_mode: 3'h0, dst_reg: 3'h0};

    typedef struct packed {
        logic [31:0] src;
        logic [31:0] dst;
    } operands_t;

    typedef struct packed {
        logic [31:0] value;
        logic [2:0] dst_mode;
        logic [2:0] dst_reg;
    } result_t;

    localparam result_t RESULT_RESET = '{
        value: 32'h0000_0000, dst_mode: 3'h0, dst_reg: 3'h0};

endpackage

// >>> src/integer_add_group_exec.sv
// decode and execute for the decimal add, binary add and address add
// sequencer presents an opcode, gets decode back, then supplies operands
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - decimal add sums source, destination, extend
// - decimal add is byte only
// - path bit picks registers or predecrement memory
// - two fields name destination and source
// - decimal carry sets carry; N,V left alone
// - nonzero decimal result clears zero, else keeps
// - extend copies carry for decimal and binary
// - binary add at byte, word or long
// - binary add sets N,Z,V,C from result
// - operation mode gives size and direction
// - register field selects a data register
// - ea mode and register fields decode fully
// - ea source takes all modes, address not byte
// - ea destination must be memory alterable
// - data register destination uses register form
// - address add full width, flags untouched
// - word address add sign-extends source
// - register field names an address register
// - address add accepts every source mode
module integer_add_group_exec (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic op_valid,
    input wire logic [15:0] opcode,
    input wire logic ops_valid,
    input wire add_group_pkg::operands_t ops,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic dec_valid,
    output add_group_pkg::decode_t dec,
    output logic illegal_trap,
    output logic res_valid,
    output add_group_pkg::result_t res,
    output logic [4:0] ccr,
    output logic [31:0] reg_rdata
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_OPERANDS = 2'b10
    } state_t;

    // byte decimal add, returns {carry, sum}
    function automatic logic [8:0] bcd_add(input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic xin);
        logic [4:0] lo;
        logic [4:0] hi;
        logic lc;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, xin};
        lc = lo > {1'b0, add_group_pkg::BCD_NINE};
        if (lc) begin
            lo = lo + add_group_pkg::BCD_ADJ;
        end
        hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lc};
        if (hi > {1'b0, add_group_pkg::BCD_NINE}) begin
            hi = hi + add_group_pkg::BCD_ADJ;
            return {1'b1, hi[3:0], lo[3:0]};
        end
        return {1'b0, hi[3:0], lo[3:0]};
    endfunction

    // sized binary add into dst, upper dst bits kept; {c, v, n, z, value}
    function automatic logic [35:0] bin_add(input logic [31:0] a,
                                            input logic [31:0] b,
                                            input add_group_pkg::size_t sz);
        logic [32:0] s;
        logic [31:0] v;
        logic c;
        logic ov;
        logic n;
        logic z;
        s = {1'b0, a} + {1'b0, b};
        case (sz)
            add_group_pkg::SZ_BYTE: begin
                v = {b[31:8], s[7:0]};
                c = a[8] ^ b[8] ^ s[8];
                n = s[7];
                ov = (a[7] == b[7]) && (s[7] != a[7]);
                z = s[7:0] == 8'h00;
            end
            add_group_pkg::SZ_WORD: begin
                v = {b[31:16], s[15:0]};
                c = a[16] ^ b[16] ^ s[16];
                n = s[15];
                ov = (a[15] == b[15]) && (s[15] != a[15]);
                z = s[15:0] == 16'h0000;
            end
            default: begin
                v = s[31:0];
                c = s[32];
                n = s[31];
                ov = (a[31] == b[31]) && (s[31] != a[31]);
                z = s[31:0] == 32'h0000_0000;
            end
        endcase
        return {c, ov, n, z, v};
    endfunction

    // source ea legality: all modes up to immediate
    function automatic logic src_ea_ok(input logic [2:0] m,
                                       input logic [2:0] r);
        return (m != add_group_pkg::EA_EXT) ||
               (r <= add_group_pkg::EXT_IMM);
    endfunction

    state_t state;
    state_t next_state;
    add_group_pkg::decode_t held;

    // field decode
    wire logic [2:0] f_reg = opcode[11:9];
    wire logic [2:0] f_opm = opcode[8:6];
    wire logic [2:0] f_mode = opcode[5:3];
    wire logic [2:0] f_ea = opcode[2:0];
    wire logic is_decimal = (opcode[15:12] == add_group_pkg::GRP_DECIMAL) &&
                            opcode[8] &&
                            (opcode[7:4] == add_group_pkg::ZERO_NIBBLE);
    wire logic is_addgrp = opcode[15:12] == add_group_pkg::GRP_ADD;
    wire logic is_addr = is_addgrp &&
                         ((f_opm == add_group_pkg::OPM_ADDR_W) ||
                          (f_opm == add_group_pkg::OPM_ADDR_L));
    wire logic is_to_d = is_addgrp && !f_opm[2] &&
                         (f_opm != add_group_pkg::OPM_ADDR_W);
    wire logic is_to_ea = is_addgrp && f_opm[2] &&
                          (f_opm != add_group_pkg::OPM_ADDR_L);
    wire add_group_pkg::size_t bin_size = add_group_pkg::size_t'(f_opm[1:0]);

    // source: any mode, direct address not at byte size
    wire logic src_ok = src_ea_ok(f_mode, f_ea) &&
                        !((f_mode == add_group_pkg::EA_ADDR) &&
                          (bin_size == add_group_pkg::SZ_BYTE));
    // destination: memory alterable only
    wire logic dst_ok = (f_mode != add_group_pkg::EA_DATA) &&
                        (f_mode != add_group_pkg::EA_ADDR) &&
                        ((f_mode != add_group_pkg::EA_EXT) ||
                         (f_ea <= add_group_pkg::EXT_ABS_L));
    wire logic addr_ok = src_ea_ok(f_mode, f_ea);

    add_group_pkg::decode_t next_dec;
    always_comb begin
        next_dec = add_group_pkg::DECODE_RESET;
        next_dec.illegal = 1'b1;
        if (is_decimal) begin
            next_dec.illegal = 1'b0;
            next_dec.op = add_group_pkg::OP_DECIMAL;
            next_dec.size = add_group_pkg::SZ_BYTE;
            next_dec.src_mode = opcode[3] ? add_group_pkg::EA_PREDEC
                                          : add_group_pkg::EA_DATA;
            next_dec.dst_mode = next_dec.src_mode;
            next_dec.src_reg = f_ea;
            next_dec.dst_reg = f_reg;
        end else if (is_addr) begin
            next_dec.illegal = !addr_ok;
            next_dec.op = add_group_pkg::OP_ADDR;
            next_dec.size = f_opm[2] ? add_group_pkg::SZ_LONG
                                     : add_group_pkg::SZ_WORD;
            next_dec.src_mode = f_mode;
            next_dec.src_reg = f_ea;
            next_dec.dst_mode = add_group_pkg::EA_ADDR;
            next_dec.dst_reg = f_reg;
        end else if (is_to_d) begin
            next_dec.illegal = !src_ok;
            next_dec.op = add_group_pkg::OP_BINARY;
            next_dec.size = bin_size;
            next_dec.src_mode = f_mode;
            next_dec.src_reg = f_ea;
            next_dec.dst_mode = add_group_pkg::EA_DATA;
            next_dec.dst_reg = f_reg;
        end else if (is_to_ea) begin
            next_dec.illegal = !dst_ok;
            next_dec.op = add_group_pkg::OP_BINARY;
            next_dec.size = bin_size;
            next_dec.src_mode = add_group_pkg::EA_DATA;
            next_dec.src_reg = f_reg;
            next_dec.dst_mode = f_mode;
            next_dec.dst_reg = f_ea;
        end
        if (next_dec.illegal) begin
            next_dec.op = add_group_pkg::OP_NONE;
        end
    end

    // execute
    wire logic [8:0] dec_sum = bcd_add(ops.src[7:0], ops.dst[7:0],
                                       ccr[add_group_pkg::FL_X]);
    wire logic [35:0] bin_sum = bin_add(ops.src, ops.dst, held.size);
    // word source to an address register widens by sign first
    wire logic [31:0] addr_src = (held.size == add_group_pkg::SZ_WORD) ?
                                 {{16{ops.src[15]}}, ops.src[15:0]} :
                                 ops.src;
    wire logic [31:0] addr_sum = addr_src + ops.dst;
    wire logic exec = (state == ST_OPERANDS) && ops_valid;

    logic [31:0] next_value;
    logic [4:0] next_ccr;
    always_comb begin
        next_value = ops.dst;
        next_ccr = ccr;
        // software writes lose to an execution in the same cycle
        if (reg_wr && (reg_addr == add_group_pkg::REG_FLAGS)) begin
            next_ccr = reg_wdata[4:0];
        end
        if (exec) begin
            case (held.op)
                add_group_pkg::OP_DECIMAL: begin
                    next_value = {ops.dst[31:8], dec_sum[7:0]};
                    next_ccr = ccr;
                    next_ccr[add_group_pkg::FL_C] = dec_sum[8];
                    next_ccr[add_group_pkg::FL_X] = dec_sum[8];
                    // zero only ever cleared, so chains keep a true test
                    if (dec_sum[7:0] != 8'h00) begin
                        next_ccr[add_group_pkg::FL_Z] = 1'b0;
                    end
                end
                add_group_pkg::OP_BINARY: begin
                    next_value = bin_sum[31:0];
                    next_ccr[add_group_pkg::FL_C] = bin_sum[35];
                    next_ccr[add_group_pkg::FL_V] = bin_sum[34];
                    next_ccr[add_group_pkg::FL_N] = bin_sum[33];
                    next_ccr[add_group_pkg::FL_Z] = bin_sum[32];
                    next_ccr[add_group_pkg::FL_X] = bin_sum[35];
                end
                add_group_pkg::OP_ADDR: begin
                    next_value = addr_sum;
                    next_ccr = ccr;
                end
                default: begin
                    next_value = ops.dst;
                end
            endcase
        end
    end

    always_comb begin
        case (state)
            ST_IDLE: next_state = (op_valid && !next_dec.illegal) ?
                                  ST_OPERANDS : ST_IDLE;
            ST_OPERANDS: next_state = ops_valid ? ST_IDLE : ST_OPERANDS;
            default: next_state = ST_IDLE;
        endcase
    end

    wire logic take_op = (state == ST_IDLE) && op_valid;
    wire logic [31:0] status_word = {30'h0000_0000,
                                     state == ST_OPERANDS, held.illegal};
    wire logic [31:0] read_mux =
        (reg_addr == add_group_pkg::REG_FLAGS) ? {27'h000_0000, ccr} :
        (reg_addr == add_group_pkg::REG_STATUS) ? status_word :
        32'h0000_0000;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            held <= add_group_pkg::DECODE_RESET;
            dec <= add_group_pkg::DECODE_RESET;
            dec_valid <= 1'b0;
            illegal_trap <= 1'b0;
        end else begin
            state <= next_state;
            dec_valid <= take_op;
            illegal_trap <= take_op && next_dec.illegal;
            if (take_op) begin
                held <= next_dec;
                dec <= next_dec;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            res <= add_group_pkg::RESULT_RESET;
            res_valid <= 1'b0;
            ccr <= add_group_pkg::CCR_RESET;
            reg_rdata <= 32'h0000_0000;
        end else begin
            res_valid <= exec;
            if (exec) begin
                res <= '{value: next_value, dst_mode: held.dst_mode,
                         dst_reg: held.dst_reg};
            end
            ccr <= next_ccr;
            reg_rdata <= reg_rd ? read_mux : 32'h0000_0000;
        end
    end

endmodule // integer_add_group_exec

`default_nettype wire

// >>> test/add_group_props.sv
// port assertions for the add group decode/execute block
// bound into every integer_add_group_exec instance
`timescale 1ns/100ps
`default_nettype none
module add_group_props (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic op_valid,
    input wire logic ops_valid,
    input wire add_group_pkg::operands_t ops,
    input wire logic reg_wr,
    input wire logic dec_valid,
    input wire add_group_pkg::decode_t dec,
    input wire logic illegal_trap,
    input wire logic res_valid,
    input wire add_group_pkg::result_t res,
    input wire logic [4:0] ccr
);
    logic wait_ops;
    logic pend;
    logic take;
    logic [31:0] msk;
    logic [31:0] sext;
    // operand phase rebuilt from the ports alone
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wait_ops <= 1'b0;
        end else if (dec_valid) begin
            wait_ops <= !dec.illegal && !ops_valid;
        end else if (ops_valid) begin
            wait_ops <= 1'b0;
        end
    end
    // operands may already arrive in the decode answer cycle
    assign pend = wait_ops || (dec_valid && !dec.illegal);
    // a same-cycle flag write would blur the flag checks
    assign take = ops_valid && pend && !reg_wr;
    assign msk = (dec.size == add_group_pkg::SZ_BYTE) ? 32'h0000_00ff :
        (dec.size == add_group_pkg::SZ_WORD) ? 32'h0000_ffff : 32'hffff_ffff;
    assign sext = {{16{ops.src[15]}}, ops.src[15:0]} + ops.dst;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_decode_latency: assert property (op_valid && !pend
        |=> dec_valid) else $error("decode missing");
    a_trap_decode: assert property (illegal_trap |-> dec_valid && dec.illegal
        && dec.op == add_group_pkg::OP_NONE) else $error("bad trap");
    a_trap_raised: assert property (dec_valid && dec.illegal
        |-> illegal_trap) else $error("trap missing");
    a_illegal_no_result: assert property (dec_valid && dec.illegal
        |-> !res_valid [*3]) else $error("result after illegal");
    a_result_latency: assert property (ops_valid && pend
        |=> res_valid) else $error("result missing");
    a_addr_flags_kept: assert property (take
        && dec.op == add_group_pkg::OP_ADDR |=> $stable(ccr))
        else $error("address add moved flags");
    a_decimal_flags: assert property (take
        && dec.op == add_group_pkg::OP_DECIMAL |=> !$rose(ccr[2])
        && ccr[3] == $past(ccr[3]) && ccr[1] == $past(ccr[1]))
        else $error("decimal flags wrong");
    a_extend_carry: assert property (take && dec.op inside
        {add_group_pkg::OP_DECIMAL, add_group_pkg::OP_BINARY}
        |=> ccr[4] == ccr[0]) else $error("extend differs from carry");
    a_binary_zero: assert property (take
        && dec.op == add_group_pkg::OP_BINARY
        |=> ccr[2] == ((res.value & msk) == 32'h0)) else $error("zero flag");
    a_addr_word_sext: assert property (take
        && dec.op == add_group_pkg::OP_ADDR
        && dec.size == add_group_pkg::SZ_WORD |=> res.value == $past(sext))
        else $error("word address add");
    a_addr_dest: assert property (dec_valid
        && dec.op == add_group_pkg::OP_ADDR
        |-> dec.dst_mode == add_group_pkg::EA_ADDR) else $error("dest kind");
endmodule // add_group_props

bind integer_add_group_exec add_group_props props_i (.ref_clk, .resetn,
    .op_valid, .ops_valid, .ops, .reg_wr, .dec_valid, .dec, .illegal_trap,
    .res_valid, .res, .ccr);
`default_nettype wire

// >>> test/op_sequencer_model.sv
// sequencer model: offers one opcode, then one operand pair if legal
// bench raises req for a cycle; gap adds idle cycles before operands
`timescale 1ns/100ps
`default_nettype none
module op_sequencer_model (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic req,
    input wire logic [15:0] req_op,
    input wire logic [31:0] req_src,
    input wire logic [31:0] req_dst,
    input wire logic [3:0] gap,
    input wire logic dec_valid,
    input wire logic illegal_trap,
    input wire logic res_valid,
    output logic op_valid,
    output logic [15:0] opcode,
    output logic ops_valid,
    output add_group_pkg::operands_t ops,
    output logic done
);
    logic [1:0] st;
    logic [3:0] cnt;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st <= 2'h0;
            cnt <= 4'h0;
            op_valid <= 1'b0;
            opcode <= 16'h0000;
            ops_valid <= 1'b0;
            ops <= '0;
            done <= 1'b0;
        end else begin
            op_valid <= 1'b0;
            ops_valid <= 1'b0;
            done <= 1'b0;
            // idle lines toggle so a stale value is never reused
            opcode <= ~opcode;
            ops <= ~ops;
            case (st)
                2'h0: if (req) begin
                    op_valid <= 1'b1;
                    opcode <= req_op;
                    st <= 2'h1;
                end
                2'h1: if (dec_valid) begin
                    done <= illegal_trap;
                    st <= illegal_trap ? 2'h0 : 2'h2;
                    cnt <= gap;
                end
                2'h2: if (cnt == 4'h0) begin
                    ops_valid <= 1'b1;
                    ops <= '{src: req_src, dst: req_dst};
                    st <= 2'h3;
                end else begin
                    cnt <= cnt - 4'h1;
                end
                default: if (res_valid) begin
                    done <= 1'b1;
                    st <= 2'h0;
                end
            endcase
        end
    end
endmodule // op_sequencer_model
`default_nettype wire

// >>> test/integer_add_group_exec_tb.sv
// self-checking bench for the add group decode/execute block
// opcodes go through the sequencer model, flags through the register port
`timescale 1ns/100ps
`default_nettype none
module integer_add_group_exec_tb;
    logic ref_clk, resetn, op_valid, ops_valid, reg_wr, reg_rd;
    logic dec_valid, illegal_trap, res_valid, req, done;
    logic [15:0] opcode, req_op;
    logic [31:0] reg_wdata, reg_rdata, req_src, req_dst, exp_v;
    logic [3:0] reg_addr, gap;
    logic [4:0] ccr, exp_ccr;
    logic [15:0] bad [7] = '{16'hd101, 16'hd148, 16'hd1bc, 16'hd13a,
        16'hd008, 16'h4e71, 16'hc1c0};
    add_group_pkg::operands_t ops;
    add_group_pkg::decode_t dec;
    add_group_pkg::result_t res;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;

    integer_add_group_exec dut (.ref_clk, .resetn, .op_valid, .opcode,
        .ops_valid, .ops, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .dec_valid, .dec, .illegal_trap, .res_valid, .res, .ccr, .reg_rdata);
    op_sequencer_model seq (.ref_clk, .resetn, .req, .req_op, .req_src,
        .req_dst, .gap, .dec_valid, .illegal_trap, .res_valid, .op_valid,
        .opcode, .ops_valid, .ops, .done);

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            $display("[ERR] %0t timeout", $time);
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] got, exp, input string what);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic note(input string s);
        $display("%s done, errors %0d", s, err_total);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        if (a == 4'h0) exp_ccr = v[4:0];
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        check(reg_rdata, e, "read data");
    endtask

    task automatic predict(input logic [15:0] o, input logic [31:0] s, d);
        logic [4:0] lo, hi;
        logic [32:0] sum;
        logic [31:0] m;
        int w;
        if (o[15:12] == 4'hc) begin
            lo = s[3:0] + d[3:0] + exp_ccr[4];
            if (lo > 5'h09) lo = lo + 5'h06;
            hi = s[7:4] + d[7:4] + lo[4];
            if (hi > 5'h09) hi = hi + 5'h06;
            exp_v = {d[31:8], hi[3:0], lo[3:0]};
            exp_ccr[4] = hi[4];
            exp_ccr[0] = hi[4];
            if (exp_v[7:0] != 8'h00) exp_ccr[2] = 1'b0;
        end else if (o[7:6] == 2'h3) begin
            exp_v = (o[8] ? s : {{16{s[15]}}, s[15:0]}) + d;
        end else begin
            w = (o[7:6] == 2'h0) ? 8 : (o[7:6] == 2'h1) ? 16 : 32;
            m = (w == 32) ? 32'hffff_ffff : (32'h1 << w) - 32'h1;
            sum = {1'b0, s & m} + {1'b0, d & m};
            exp_v = (d & ~m) | (sum[31:0] & m);
            exp_ccr[0] = sum[w];
            exp_ccr[4] = sum[w];
            exp_ccr[3] = sum[w-1];
            exp_ccr[2] = (sum[31:0] & m) == 32'h0;
            exp_ccr[1] = s[w-1] == d[w-1] && sum[w-1] != s[w-1];
        end
    endtask

    task automatic run(input logic [15:0] o, input logic ill,
            input logic [31:0] s, d);
        int n;
        req_op <= o;
        req_src <= s;
        req_dst <= d;
        req <= 1'b1;
        @(posedge ref_clk);
        req <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            n++;
        end
        check(dec.illegal, ill, "illegal");
        if (!ill) begin
            predict(o, s, d);
            check(res.value, exp_v, "value");
        end
        check(ccr, exp_ccr, "flags");
    endtask

    initial begin
        logic [2:0] opm;
        resetn = 1'b0;
        {reg_wr, reg_rd, req} = 3'h0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        {req_op, req_src, req_dst} = '0;
        gap = 4'h0;
        exp_ccr = 5'h00;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        check(ccr, 32'h0, "flags at reset");
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h0);
        wr(4'h8, 32'hffff_ffff);
        rd(4'h8, 32'h0);
        note("registers");
        wr(4'h0, 32'h14);
        rd(4'h0, 32'h14);
        run(16'hc101, 1'b0, 32'h45, 32'h1234_5638);
        check({dec.src_mode, dec.src_reg, dec.dst_reg}, 32'h008, "regs");
        wr(4'h0, 32'h04);
        run(16'hc109, 1'b0, 32'h99, 32'h01);
        check({dec.src_mode, dec.src_reg, dec.dst_reg}, 32'h108, "mem");
        check(dec.size, add_group_pkg::SZ_BYTE, "decimal size");
        note("decimal");
        for (int i = 0; i < 6; i++) begin
            opm = (i < 3) ? 3'(i) : 3'(i + 1);
            gap <= (i > 2) ? 4'h3 : 4'h0;
            run({4'hd, 3'h2, opm, (i < 3) ? 6'h03 : 6'h13}, 1'b0,
                32'h7fff_ffff, 32'h0000_0001);
            check(dec.dst_reg, (i < 3) ? 32'h2 : 32'h3, "reg field");
            check({res.dst_mode, res.dst_reg}, (i < 3) ? 32'h02 : 32'h13,
                "result dest");
            run({4'hd, 3'h2, opm, (i < 3) ? 6'h03 : 6'h13}, 1'b0,
                32'h8080_8080, 32'hffff_8080);
        end
        note("binary");
        for (int k = 0; k < 12; k++) begin
            run({4'hd, 3'h1, 3'h1, (k < 7) ? {3'(k), 3'h5} :
                {3'h7, 3'(k - 7)}}, 1'b0, 32'h1, 32'hfffe);
        end
        note("source modes");
        wr(4'h0, 32'h1f);
        run(16'hd0c0, 1'b0, 32'h0000_8000, 32'h0000_0001);
        run(16'hd3fc, 1'b0, 32'hffff_ffff, 32'h0000_0001);
        check({dec.dst_mode, dec.dst_reg}, 32'h09, "address dest");
        check({res.dst_mode, res.dst_reg}, 32'h09, "result dest");
        note("address add");
        foreach (bad[k]) begin
            run(bad[k], 1'b1, 32'h0, 32'h0);
            rd(4'h4, 32'h1);
        end
        note("illegal");
        give_verdict();
    end
endmodule // integer_add_group_exec_tb
`default_nettype wire
